// File: include/iev_params.svh
/*
 * Offsets, field positions, reset values and timing counts for the bus event flag block.
 * Assumes inclusion by bare name from the design module, checker and bench.
 */
`ifndef IEV_PARAMS_SVH
`define IEV_PARAMS_SVH

// ********************************
// register offsets
// ********************************
`define IEV_OFS_CTRL        4'h0
`define IEV_OFS_STATUS      4'h1
`define IEV_OFS_IRQ_STAT    4'h2
`define IEV_OFS_IRQ_MASK    4'h3

// ********************************
// bus_control_reg fields
// ********************************
`define IEV_CTRL_EXIT_BIT   6
`define IEV_CTRL_EN_BIT     7

// ********************************
// bus_event_status fields
// ********************************
`define IEV_STAT_ACK_BIT    2
`define IEV_STAT_STD_BIT    1
`define IEV_STAT_SPD_BIT    0

// ********************************
// interrupt status fields
// ********************************
`define IEV_IRQ_ACK_BIT     0
`define IEV_IRQ_START_BIT   1
`define IEV_IRQ_STOP_BIT    2

// ********************************
// reset values and counts
// ********************************
`define IEV_CTRL_RST        8'h00
`define IEV_MASK_RST        8'h00
`define IEV_BITS_PER_BYTE   4'h9

`endif

// File: include/iev_pkg.sv
/*
 * Types shared by the bus event flag block.
 * Assumes the params header sits on the include path.
 */
package iev_pkg;

	// register port request from the software side
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} iev_req_t;

	// one-cycle bus events seen on the sampled lines
	typedef struct packed {
		logic start;
		logic stop;
		logic scl_rise;
	} iev_evt_t;

endpackage : iev_pkg

// File: src/iev_flags.sv
/*
 * Acknowledge, start and stop detection flags of a two-wire bus interface.
 * Assumes the bus lines are asynchronous pins and the register port runs on MCLK_IN.
 */
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "iev_params.svh"

module iev_flags
	import iev_pkg::*;
(
	input  wire logic       MCLK_IN,      // system clock, 125 MHz
	input  wire logic       RST_N_IN,     // async reset, active low
	input  wire logic [3:0] ADDR_IN,      // register address
	input  wire logic [7:0] WDATA_IN,     // write data
	input  wire logic       WR_IN,        // write strobe
	input  wire logic       RD_IN,        // read strobe
	input  wire logic       SCL_IN,       // clock_line_pin level
	input  wire logic       SDA_IN,       // data_line_pin level
	output logic      [7:0] RDATA_OUT,    // read data, cycle after strobe
	output logic            ACK_FLAG_OUT, // ack_detected_flag
	output logic            STD_FLAG_OUT, // start_detected_flag
	output logic            SPD_FLAG_OUT, // stop_detected_flag
	output logic            IRQ_OUT       // level interrupt
);

	// ********************************
	// pin synchronisers
	// ********************************
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic       scl_q;
	logic       sda_q;

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q      <= 1'h1;
			sda_q      <= 1'h1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], SCL_IN};
			sda_sync_q <= {sda_sync_q[0], SDA_IN};
			scl_q      <= scl_sync_q[1];
			sda_q      <= sda_sync_q[1];
		end
	end

	// ********************************
	// register port decode
	// ********************************
	iev_req_t req;
	assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

	wire wr_ctrl = req.wr && (req.addr == `IEV_OFS_CTRL);
	wire wr_stat = req.wr && (req.addr == `IEV_OFS_IRQ_STAT);
	wire wr_mask = req.wr && (req.addr == `IEV_OFS_IRQ_MASK);

	logic [7:0] ctrl_q;
	logic [7:0] irq_stat_q;
	logic [7:0] irq_mask_q;

	wire en_now      = ctrl_q[`IEV_CTRL_EN_BIT];
	wire en_next     = wr_ctrl ? req.wdata[`IEV_CTRL_EN_BIT] : en_now;
	wire disable_evt = en_now && !en_next;
	// exit command is a self-clearing strobe; it never reads back as one
	wire exit_cmd    = wr_ctrl && req.wdata[`IEV_CTRL_EXIT_BIT];

	// ********************************
	// bus event detection
	// ********************************
	iev_evt_t evt;
	assign evt.start    = en_now && scl_q && scl_sync_q[1] && sda_q && !sda_sync_q[1];
	assign evt.stop     = en_now && scl_q && scl_sync_q[1] && !sda_q && sda_sync_q[1];
	assign evt.scl_rise = en_now && !scl_q && scl_sync_q[1];

	// clock pulse count within the current byte, 0..8
	logic [3:0] bit_cnt_q;
	logic       in_xfer_q;
	logic       addr_done_q;
	logic       spd_arm_q;
	logic       ack_q;
	logic       std_q;
	logic       spd_q;

	wire ninth_rise = evt.scl_rise && in_xfer_q && (bit_cnt_q == `IEV_BITS_PER_BYTE - 4'h1);
	wire first_rise = evt.scl_rise && in_xfer_q && (bit_cnt_q == 4'h0);
	wire [3:0] cnt_d = ninth_rise ? 4'h0 : bit_cnt_q + 4'h1;
	wire hard_clr    = disable_evt || !en_now;

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			bit_cnt_q   <= 4'h0;
			in_xfer_q   <= 1'h0;
			addr_done_q <= 1'h0;
			spd_arm_q   <= 1'h0;
		end else if (hard_clr || evt.stop) begin
			bit_cnt_q   <= 4'h0;
			in_xfer_q   <= 1'h0;
			addr_done_q <= 1'h0;
			spd_arm_q   <= 1'h0;
		end else if (evt.start) begin
			bit_cnt_q   <= 4'h0;
			in_xfer_q   <= 1'h1;
			addr_done_q <= 1'h0;
			spd_arm_q   <= 1'h1;
		end else if (evt.scl_rise && in_xfer_q) begin
			bit_cnt_q <= cnt_d;
			if (ninth_rise) begin
				addr_done_q <= 1'h1;
			end
			if (first_rise) begin
				spd_arm_q <= 1'h0;
			end
		end
	end

	// ********************************
	// detection flags
	// ********************************
	// flags take no software write; only bus events and commands move them
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ack_q <= 1'h0;
			std_q <= 1'h0;
			spd_q <= 1'h0;
		end else begin
			if (ninth_rise && !sda_sync_q[1] && !exit_cmd && !hard_clr) begin
				ack_q <= 1'h1;
			end else if (first_rise || evt.stop || exit_cmd || hard_clr) begin
				ack_q <= 1'h0;
			end
			if (evt.start && !exit_cmd && !hard_clr) begin
				std_q <= 1'h1;
			end else if ((first_rise && addr_done_q) || evt.stop || exit_cmd || hard_clr) begin
				std_q <= 1'h0;
			end
			if (evt.stop && !hard_clr) begin
				spd_q <= 1'h1;
			// stop flag held until address byte first clock
			end else if ((first_rise && spd_arm_q) || hard_clr) begin
				spd_q <= 1'h0;
			end
		end
	end

	// ********************************
	// control, interrupt and read-back registers
	// ********************************
	wire [7:0] irq_evt = {5'h00, evt.stop, evt.start, ninth_rise && !sda_sync_q[1]};
	wire [7:0] status  = {5'h00, ack_q, std_q, spd_q};
	wire [7:0] rd_mux  = (req.addr == `IEV_OFS_CTRL)     ? {ctrl_q[7], 7'h00} :
	                     (req.addr == `IEV_OFS_STATUS)   ? status :
	                     (req.addr == `IEV_OFS_IRQ_STAT) ? irq_stat_q :
	                     (req.addr == `IEV_OFS_IRQ_MASK) ? irq_mask_q : 8'h00;

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_q     <= `IEV_CTRL_RST;
			irq_stat_q <= 8'h00;
			irq_mask_q <= `IEV_MASK_RST;
			RDATA_OUT  <= 8'h00;
			IRQ_OUT    <= 1'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= {req.wdata[`IEV_CTRL_EN_BIT], 7'h00};
			end
			if (wr_mask) begin
				irq_mask_q <= req.wdata & 8'h07;
			end
			// a new event wins over a write-one clear in the same cycle
			irq_stat_q <= ((irq_stat_q & ~(wr_stat ? req.wdata : 8'h00)) | irq_evt) & 8'h07;
			RDATA_OUT  <= req.rd ? rd_mux : 8'h00;
			IRQ_OUT    <= |(irq_stat_q & irq_mask_q);
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ACK_FLAG_OUT <= 1'h0;
			STD_FLAG_OUT <= 1'h0;
			SPD_FLAG_OUT <= 1'h0;
		end else begin
			ACK_FLAG_OUT <= ack_q;
			STD_FLAG_OUT <= std_q;
			SPD_FLAG_OUT <= spd_q;
		end
	end

endmodule : iev_flags

// File: verif/iev_flags_sva.sv
/* checker for the bus event flag block ports
 * assumes binding into iev_flags, one clock domain MCLK_IN */
`timescale 1ns/100ps
`include "iev_params.svh"
module iev_flags_sva (
	input wire logic       MCLK_IN,
	input wire logic       RST_N_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic       WR_IN,
	input wire logic       RD_IN,
	input wire logic       SCL_IN,
	input wire logic       SDA_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic       ACK_FLAG_OUT,
	input wire logic       STD_FLAG_OUT,
	input wire logic       SPD_FLAG_OUT,
	input wire logic       IRQ_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire logic ctl_wr = WR_IN && ADDR_IN == `IEV_OFS_CTRL;
	rd_idle_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
		else $error("read data not zero");
	start_set_a: assert property ($rose(STD_FLAG_OUT) |-> SCL_IN && !SDA_IN)
		else $error("start flag without start");
	stop_set_a: assert property ($rose(SPD_FLAG_OUT) |-> SCL_IN && SDA_IN)
		else $error("stop flag without stop");
	stop_clears_a: assert property ($rose(SPD_FLAG_OUT) |-> !ACK_FLAG_OUT && !STD_FLAG_OUT)
		else $error("stop left flags set");
	ack_set_a: assert property ($rose(ACK_FLAG_OUT) |-> SCL_IN && !SDA_IN)
		else $error("ack flag without low data");
	ack_clear_a: assert property ($fell(ACK_FLAG_OUT) |-> SCL_IN || $past(WR_IN, 2) || $past(WR_IN, 3))
		else $error("ack flag cleared off clock");
	stop_hold_a: assert property ($fell(SPD_FLAG_OUT) |-> SCL_IN || $past(WR_IN, 2) || $past(WR_IN, 3))
		else $error("stop flag cleared early");
	off_clear_a: assert property (ctl_wr && !WDATA_IN[7] |-> ##[1:4] !(ACK_FLAG_OUT | STD_FLAG_OUT | SPD_FLAG_OUT))
		else $error("flags kept while disabled");
	exit_clear_a: assert property (ctl_wr && WDATA_IN[6] |-> ##[1:4] !ACK_FLAG_OUT && !STD_FLAG_OUT)
		else $error("exit left flags set");
	ack_seen_c: cover property ($rose(ACK_FLAG_OUT));
	stop_seen_c: cover property ($rose(SPD_FLAG_OUT));
	irq_seen_c: cover property ($rose(IRQ_OUT));
endmodule : iev_flags_sva
bind iev_flags iev_flags_sva u_sva (.*);

// File: verif/iev_bus_master.sv
/* two-wire bus master with addressed slave ack
 * assumes lines idle high by pull-up, bit time 160 ns */
`timescale 1ns/100ps
module iev_bus_master (
	output logic scl_out, // clock line level
	output logic sda_out  // data line level
);
	// clock stands high between frames; data moves while clock is low, except at start and stop
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic start_c();
		sda_out = 1'b0;
		#80 scl_out = 1'b0;
	endtask : start_c
	task automatic send_byte(input logic [7:0] b, input logic ack);
		for (int i = 0; i < 9; i++) begin
			// ninth bit: slave pulls low to ack, else releases to pull-up
			#40 sda_out = (i < 8) ? b[7] : !ack;
			b = b << 1;
			#40 scl_out = 1'b1;
			#80 scl_out = 1'b0;
		end
	endtask : send_byte
	task automatic stop_c();
		#40 sda_out = 1'b0;
		#40 scl_out = 1'b1;
		#80 sda_out = 1'b1;
		#80;
	endtask : stop_c
endmodule : iev_bus_master

// File: verif/tb_top.sv
/* bench for the bus event flag block
 * assumes package, header and bus master model compiled first */
`timescale 1ns/100ps
`include "iev_params.svh"
module tb_top;
	int         fails = 0;
	int         tests_run = 0;
	logic       mclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       ack, std, spd, irq, scl, sda;
	iev_flags dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
		.RD_IN(rd), .SCL_IN(scl), .SDA_IN(sda), .RDATA_OUT(rdata), .ACK_FLAG_OUT(ack),
		.STD_FLAG_OUT(std), .SPD_FLAG_OUT(spd), .IRQ_OUT(irq));
	iev_bus_master bm (.scl_out(scl), .sda_out(sda));
	initial forever #4 mclk = ~mclk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd_reg
	// pins and status register must agree after the sync delay
	task automatic flags(input logic [7:0] e);
		repeat (8) @(posedge mclk);
		// look after the edge so the registered flags have settled
		#1 chk({5'h00, ack, std, spd}, e);
		rd_reg(`IEV_OFS_STATUS, e);
	endtask : flags
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		fails++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		flags(8'h00);
		rd_reg(`IEV_OFS_CTRL, 8'h00);
		wr_reg(`IEV_OFS_CTRL, 8'h80);
		rd_reg(`IEV_OFS_CTRL, 8'h80);
		bm.start_c();
		flags(8'h02);
		bm.send_byte(8'hA4, 1'b1);
		flags(8'h06);
		wr_reg(`IEV_OFS_STATUS, 8'hF9);
		flags(8'h06);
		bm.send_byte(8'h5B, 1'b0);
		flags(8'h00);
		bm.stop_c();
		flags(8'h01);
		chk({7'h00, irq}, 8'h00);
		rd_reg(`IEV_OFS_IRQ_STAT, 8'h07);
		wr_reg(`IEV_OFS_IRQ_MASK, 8'h04);
		repeat (4) @(posedge mclk);
		#1 chk({7'h00, irq}, 8'h01);
		wr_reg(`IEV_OFS_IRQ_STAT, 8'h07);
		repeat (4) @(posedge mclk);
		#1 chk({7'h00, irq}, 8'h00);
		rd_reg(`IEV_OFS_IRQ_STAT, 8'h00);
		bm.start_c();
		flags(8'h03);
		bm.send_byte(8'hA4, 1'b1);
		flags(8'h06);
		wr_reg(`IEV_OFS_CTRL, 8'hC0);
		flags(8'h00);
		rd_reg(`IEV_OFS_CTRL, 8'h80);
		bm.stop_c();
		flags(8'h01);
		wr_reg(`IEV_OFS_CTRL, 8'h00);
		flags(8'h00);
		rd_reg(4'hF, 8'h00);
		// mid-run reset with the start flag up must clear flags and control
		wr_reg(`IEV_OFS_CTRL, 8'h80);
		bm.start_c();
		flags(8'h02);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		flags(8'h00);
		rd_reg(`IEV_OFS_CTRL, 8'h00);
		give_verdict();
	end
endmodule : tb_top
